// File: rtl/ueb_core.sv
`timescale 1ns/1ps
// Byte FIFO between receive path and buffer writer
module ueb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers and count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end
endmodule

// Endpoint control, status queue, descriptor table and shared RAM
module ueb_core
  import ueb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Processor data-memory port
  input wire logic [11:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Transfer complete flag and its clear
  output logic transfer_complete_flag,
  input wire logic trn_clr,
  // Suspend state and frame validity
  input wire logic suspend_flag,
  output logic frame_valid,
  // Decoded tokens from the line
  input wire logic tok_valid,
  output logic tok_ready,
  input wire ueb_tok_type tok,
  input wire logic bus_reset_flag,
  // Handshake to send
  output logic hs_valid,
  output logic [3:0] hs_pid,
  // Received data bytes
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // Transmit data bytes
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data
);
  logic [7:0] ram [0:RAM_BYTES-1];
  logic [4:0] pipe_ctrl_r [PIPE_COUNT];
  logic [7:0] dev_addr_r;
  logic [10:0] frame_r;
  ueb_stat_type stq_r [STAT_DEPTH];
  logic [1:0] sq_rd_r;
  logic [1:0] sq_wr_r;
  logic [2:0] sq_cnt_r;
  logic flag_r;
  ueb_state_type state_r;
  ueb_state_type state_nxt;
  ueb_tok_type tok_r;
  logic [11:0] bd_base_r;
  logic [9:0] bd_cnt_r;
  logic [9:0] xfer_r;
  logic [11:0] ptr_r;
  logic [11:0] ptr_nxt;
  logic [7:0] cpu_rdata_r;
  logic hs_valid_r;
  logic [3:0] hs_pid_r;
  logic [7:0] tx_data_r;
  logic frame_valid_r;
  // Token decode
  logic tok_take;
  logic tok_mine;
  logic tok_is_in;
  logic tok_is_setup;
  logic [4:0] ep_ctl;
  logic ep_allowed;
  logic [11:0] tok_bd;
  logic sq_full;
  logic sq_push;
  logic sq_pop;
  logic stall_now;
  // Receive FIFO drain
  logic rf_valid;
  logic rf_ready;
  logic [8:0] rf_data;
  logic rx_take;
  logic tx_take;
  logic [11:0] cpu_ep;

  // Bytes from the line queue here so a slow buffer writer stalls the source
  ueb_fifo #(.WIDTH(RX_WIDTH), .DEPTH(RX_DEPTH)) u_rxq (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_last, rx_data}),
    .out_valid(rf_valid),
    .out_ready(rf_ready),
    .out_data(rf_data)
  );

  // Token classification
  assign tok_ready = state_r == ST_IDLE;
  assign tok_take = tok_valid && tok_ready;
  assign tok_mine = tok.addr == dev_addr_r[6:0];
  assign tok_is_in = tok.pid == PID_IN;
  assign tok_is_setup = tok.pid == PID_SETUP;
  assign ep_ctl = pipe_ctrl_r[tok.endp];
  assign tok_bd = BDT_BASE + {4'h0, tok.endp, tok_is_in, 1'b0, 2'b00};
  assign sq_full = sq_cnt_r == 3'(STAT_DEPTH);
  // Direction enables and SETUP refusal gate the token
  always_comb
  begin
    ep_allowed = 1'b0;
    if (tok_is_in)
      ep_allowed = ep_ctl[IN_EN_BIT];
    else if (tok.pid == PID_OUT)
      ep_allowed = ep_ctl[OUT_EN_BIT];
    else if (tok_is_setup)
      ep_allowed = ep_ctl[OUT_EN_BIT] && ep_ctl[IN_EN_BIT] && !ep_ctl[SETUP_OFF_BIT];
  end

  // Stall when the owned descriptor asks for it, except on SETUP
  assign stall_now = state_r == ST_BD && ram[bd_base_r][OWN_BIT]
    && ram[bd_base_r][BSTALL_BIT] && tok_r.pid != PID_SETUP;
  assign rx_take = state_r == ST_RX && rf_valid;
  assign rf_ready = state_r == ST_RX;
  assign tx_valid = state_r == ST_TX && xfer_r != bd_cnt_r;
  assign tx_take = tx_valid && tx_ready;
  assign tx_data = tx_data_r;
  assign sq_push = state_r == ST_DONE;
  assign sq_pop = trn_clr && sq_cnt_r != '0;

  // Transfer state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (tok_take && tok_mine && tok.pid != PID_SOF && ep_allowed && !sq_full)
          state_nxt = ST_BD;
      ST_BD:
        if (!ram[bd_base_r][OWN_BIT] || stall_now)
          state_nxt = ST_IDLE;
        else if (tok_r.pid == PID_IN)
          state_nxt = ST_TX;
        else
          state_nxt = ST_RX;
      ST_RX:
        if (rx_take && rf_data[8])
          state_nxt = ST_DONE;
      ST_TX:
        if (!tx_valid)
          state_nxt = ST_DONE;
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Buffer pointer: load from descriptor, step per byte
  always_comb
  begin
    ptr_nxt = ptr_r;
    if (state_r == ST_BD)
      ptr_nxt = {ram[bd_base_r + 12'h003][3:0], ram[bd_base_r + 12'h002]};
    else if (rx_take || tx_take)
      ptr_nxt = ptr_r + 12'h001;
  end

  // Engine registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      tok_r <= '0;
      bd_base_r <= BDT_BASE;
      bd_cnt_r <= '0;
      xfer_r <= '0;
      ptr_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      if (tok_take)
      begin
        tok_r <= tok;
        bd_base_r <= tok_bd;
      end
      if (state_r == ST_BD)
      begin
        bd_cnt_r <= {ram[bd_base_r][1:0], ram[bd_base_r + 12'h001]};
        xfer_r <= '0;
      end
      else if ((rx_take && !rf_data[8] && xfer_r != bd_cnt_r) || tx_take)
        xfer_r <= xfer_r + 10'h001;
    end
  end

  // Transmit byte prefetched from the next buffer location
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tx_data_r <= '0;
    else
      tx_data_r <= ram[ptr_nxt];
  end

  // Handshake choice: NAK on full queue or not owned, STALL, or ACK if allowed
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      hs_valid_r <= 1'b0;
      hs_pid_r <= '0;
    end
    else
    begin
      hs_valid_r <= 1'b0;
      if (state_r == ST_IDLE && tok_take && tok_mine && tok.pid != PID_SOF
          && ep_allowed && sq_full && ep_ctl[HSK_BIT])
      begin
        hs_valid_r <= 1'b1;
        hs_pid_r <= PID_NAK;
      end
      else if (state_r == ST_BD && pipe_ctrl_r[tok_r.endp][HSK_BIT]
               && (!ram[bd_base_r][OWN_BIT] || stall_now))
      begin
        hs_valid_r <= 1'b1;
        hs_pid_r <= stall_now ? PID_STALL : PID_NAK;
      end
      else if (state_r == ST_DONE && tok_r.pid != PID_IN
               && pipe_ctrl_r[tok_r.endp][HSK_BIT])
      begin
        hs_valid_r <= 1'b1;
        hs_pid_r <= PID_ACK;
      end
    end
  end
  assign hs_valid = hs_valid_r;
  assign hs_pid = hs_pid_r;

  // Shared RAM: processor writes, engine writes data and descriptor update
  always_ff @(posedge ref_clk)
  begin
    if (cpu_wr && cpu_addr <= RAM_LAST)
      ram[cpu_addr] <= cpu_wdata;
    if (rx_take && !rf_data[8] && xfer_r != bd_cnt_r)
      ram[ptr_r] <= rf_data[7:0];
    if (state_r == ST_DONE)
    begin
      ram[bd_base_r] <= {1'b0, 1'b0, tok_r.pid, xfer_r[9:8]};
      ram[bd_base_r + 12'h001] <= xfer_r[7:0];
    end
  end

  // Per-endpoint control registers
  assign cpu_ep = cpu_addr - PIPE_CTRL_BASE;
  generate
    for (genvar i = 0; i < PIPE_COUNT; i++)
    begin : g_pipe
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          pipe_ctrl_r[i] <= '0;
        else
        begin
          if (cpu_wr && cpu_ep == 12'(i))
            pipe_ctrl_r[i] <= cpu_wdata[4:0];
          if (stall_now && tok_r.endp == 4'(i))
            pipe_ctrl_r[i][STALL_BIT] <= 1'b1;
        end
      end
    end
  endgenerate

  // Device address: cleared by bus reset, loaded by firmware
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      dev_addr_r <= ADDR_RESET;
    else if (bus_reset_flag)
      dev_addr_r <= ADDR_RESET;
    else if (cpu_wr && cpu_addr == DEV_ADDR_ADDR)
      dev_addr_r <= cpu_wdata;
  end

  // Frame number captured on each SOF; processor writes ignored
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      frame_r <= '0;
    else if (tok_take && tok.pid == PID_SOF) // SOF carries the frame, not an address
      frame_r <= {tok.endp, tok.addr};
  end

  // Frame number trusted only outside suspend
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      frame_valid_r <= 1'b0;
    else
      frame_valid_r <= !suspend_flag;
  end
  assign frame_valid = frame_valid_r;

  // Status queue; a push in the clear cycle is kept
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sq_rd_r <= '0;
      sq_wr_r <= '0;
      sq_cnt_r <= '0;
    end
    else
    begin
      if (sq_push)
      begin
        stq_r[sq_wr_r] <= '{endp: tok_r.endp, dir: tok_r.pid == PID_IN, odd: 1'b0};
        sq_wr_r <= sq_wr_r + 2'd1;
      end
      if (sq_pop)
        sq_rd_r <= sq_rd_r + 2'd1;
      sq_cnt_r <= sq_cnt_r + 3'(sq_push) - 3'(sq_pop);
    end
  end

  // Flag drops for one cycle on clear, then reasserts if entries remain
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flag_r <= 1'b0;
    else
      flag_r <= !trn_clr && sq_cnt_r != '0;
  end
  assign transfer_complete_flag = flag_r;

  // Processor read mux
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cpu_rdata_r <= '0;
    else if (cpu_rd)
    begin
      if (cpu_addr <= RAM_LAST)
        cpu_rdata_r <= ram[cpu_addr];
      else if (cpu_ep < 12'(PIPE_COUNT))
        cpu_rdata_r <= {3'b000, pipe_ctrl_r[cpu_ep[3:0]]};
      else if (cpu_addr == LAST_STAT_ADDR)
        cpu_rdata_r <= {1'b0, stq_r[sq_rd_r].endp, stq_r[sq_rd_r].dir,
                        stq_r[sq_rd_r].odd, 1'b0};
      else if (cpu_addr == DEV_ADDR_ADDR)
        cpu_rdata_r <= dev_addr_r;
      else if (cpu_addr == FRAME_LO_ADDR)
        cpu_rdata_r <= frame_r[7:0];
      else if (cpu_addr == FRAME_HI_ADDR)
        cpu_rdata_r <= {5'b00000, frame_r[10:8]};
      else
        cpu_rdata_r <= '0;
    end
  end
  assign cpu_rdata = cpu_rdata_r;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_stat_layout: assert property (cpu_rd && cpu_addr == LAST_STAT_ADDR
    |=> cpu_rdata[7] == 1'b0 && cpu_rdata[0] == 1'b0
        && cpu_rdata[6:3] == $past(stq_r[sq_rd_r].endp))
    else $error("status read layout wrong");
  a_stat_dir: assert property (sq_push && tok_r.pid == PID_IN
    |=> stq_r[$past(sq_wr_r)].dir)
    else $error("IN direction not recorded");
  a_stall_sticky: assert property (stall_now
    |=> pipe_ctrl_r[$past(tok_r.endp)][STALL_BIT]
        && hs_valid == $past(pipe_ctrl_r[tok_r.endp][HSK_BIT])
        && (!hs_valid || hs_pid == PID_STALL))
    else $error("stall bit not set");
  a_addr_reset: assert property (bus_reset_flag |=> dev_addr_r == ADDR_RESET)
    else $error("address not cleared on bus reset");
  a_frame_ro: assert property (cpu_wr && !(tok_take && tok.pid == PID_SOF)
    |=> $stable(frame_r))
    else $error("frame number changed by write");
  a_frame_capture: assert property (tok_take && tok.pid == PID_SOF
    |=> frame_r == $past({tok.endp, tok.addr}))
    else $error("frame number not captured");
  a_nak_full: assert property (tok_take && tok_mine && tok.pid != PID_SOF
    && ep_allowed && sq_full && ep_ctl[HSK_BIT] |=> hs_valid && hs_pid == PID_NAK
    && state_r == ST_IDLE)
    else $error("no NAK with full queue");
  a_own_clear: assert property (state_r == ST_DONE
    |=> !ram[$past(bd_base_r)][OWN_BIT] ##0 sq_cnt_r != '0)
    else $error("ownership not returned");
  a_flag_reassert: assert property (trn_clr && sq_cnt_r > 3'd1
    |=> !transfer_complete_flag ##[1:2] transfer_complete_flag)
    else $error("flag did not reassert");
  a_addr_match: assert property (tok_take && !tok_mine
    |=> state_r == ST_IDLE && !hs_valid)
    else $error("foreign token answered");

  c_out_done: cover property (state_r == ST_RX ##[1:40] state_r == ST_DONE);
  c_in_done: cover property (state_r == ST_TX ##[1:40] state_r == ST_DONE);
  c_queue_full: cover property (sq_full && tok_take);
  c_stall: cover property (stall_now);
endmodule

// File: rtl/ueb_pkg.sv
package ueb_pkg;
  // Register map
  localparam logic [11:0] PIPE_CTRL_BASE = 12'hf26;
  localparam logic [11:0] LAST_STAT_ADDR = 12'hf64;
  localparam logic [11:0] DEV_ADDR_ADDR = 12'hf38;
  localparam logic [11:0] FRAME_LO_ADDR = 12'hf66;
  localparam logic [11:0] FRAME_HI_ADDR = 12'hf67;
  localparam int PIPE_COUNT = 16;
  // Shared RAM and descriptor table
  localparam int RAM_BYTES = 3776;
  localparam logic [11:0] RAM_LAST = 12'hebf;
  localparam logic [11:0] BDT_BASE = 12'h400;
  localparam logic [11:0] BDT_LAST = 12'h4ff;
  // Control register fields
  localparam int HSK_BIT = 4;
  localparam int SETUP_OFF_BIT = 3;
  localparam int OUT_EN_BIT = 2;
  localparam int IN_EN_BIT = 1;
  localparam int STALL_BIT = 0;
  // Descriptor status fields
  localparam int OWN_BIT = 7;
  localparam int BSTALL_BIT = 2;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // Token and handshake PIDs
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SOF = 4'h5;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'ha;
  localparam logic [3:0] PID_STALL = 4'he;
  // Status queue and flag timing
  localparam int STAT_DEPTH = 4;
  localparam int CLK_NS = 10;
  localparam int INSTR_CYCLE_NS = 83;
  localparam int REASSERT_CYC = (5 * INSTR_CYCLE_NS) / CLK_NS;
  localparam int RX_DEPTH = 32;
  localparam int RX_WIDTH = 9;
  typedef struct packed {logic [3:0] pid; logic [6:0] addr; logic [3:0] endp;} ueb_tok_type;
  typedef struct packed {logic [3:0] endp; logic dir; logic odd;} ueb_stat_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_BD = 3'b001, ST_RX = 3'b010, ST_TX = 3'b011, ST_DONE = 3'b100
  } ueb_state_type;
endpackage

// File: bench/ueb_host.sv
`timescale 1ns/1ps
// Host controller model: issues tokens, sends OUT data, sinks IN data
module ueb_host
  import ueb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Token link
  output logic tok_valid,
  input wire logic tok_ready,
  output ueb_tok_type tok,
  output logic bus_reset_flag,
  // Handshake from device
  input wire logic hs_valid,
  input wire logic [3:0] hs_pid,
  // Data towards device
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_last,
  // Data from device
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  logic slow = 1'b0;
  int hs_cnt = 0;
  logic [3:0] hs_last = 4'h0;
  logic [7:0] got[$];

  // Quiet link at time zero
  initial
  begin
    tok_valid = 1'b0;
    tok = '0;
    bus_reset_flag = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end

  // Offer one token and hold it until taken
  task automatic send_token(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e);
    @(posedge ref_clk);
    tok_valid <= 1'b1;
    tok <= {p, a, e};
    do @(negedge ref_clk); while (tok_ready !== 1'b1);
    @(posedge ref_clk);
    tok_valid <= 1'b0;
    tok <= ~tok; // Released lines must not keep the old token
  endtask

  // Send n bytes, then the end marker if fin is set
  task automatic send_data(input int n, input logic [7:0] first, input int fin);
    for (int i = 0; i < n + fin; i++)
    begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= first + 8'(i);
      rx_last <= (i == n);
      do @(negedge ref_clk); while (rx_ready !== 1'b1);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask

  // One-cycle bus reset
  task automatic bus_reset;
    @(posedge ref_clk);
    bus_reset_flag <= 1'b1;
    @(posedge ref_clk);
    bus_reset_flag <= 1'b0;
  endtask

  // Sink IN bytes, a slow host every other cycle, and log handshakes
  always @(posedge ref_clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (hs_valid)
    begin
      hs_cnt <= hs_cnt + 1;
      hs_last <= hs_pid;
    end
  end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the endpoint, status and descriptor logic
module testbench
  import ueb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] cpu_addr = 12'h000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic transfer_complete_flag;
  logic trn_clr = 1'b0;
  logic suspend_flag = 1'b0;
  logic frame_valid;
  logic tok_valid, tok_ready, bus_reset_flag, hs_valid;
  ueb_tok_type tok;
  logic [3:0] hs_pid;
  logic rx_valid, rx_ready, rx_last, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data;
  int n_errors = 0;
  int compares = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  ueb_core ueb_core_inst (.ref_clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata, .transfer_complete_flag, .trn_clr, .suspend_flag, .frame_valid,
    .tok_valid, .tok_ready, .tok, .bus_reset_flag, .hs_valid, .hs_pid, .rx_valid,
    .rx_ready, .rx_data, .rx_last, .tx_valid, .tx_ready, .tx_data);
  ueb_host ueb_host_inst (.ref_clk, .rst, .tok_valid, .tok_ready, .tok, .bus_reset_flag,
    .hs_valid, .hs_pid, .rx_valid, .rx_ready, .rx_data, .rx_last, .tx_valid, .tx_ready,
    .tx_data);

  // Compare a byte
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string s);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask

  // Compare a flag
  task automatic check_bit(input logic g, input logic e, input string s);
    check_byte({7'h00, g}, {7'h00, e}, s);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask

  // Read one byte and compare it
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string s);
    @(posedge ref_clk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(negedge ref_clk);
    check_byte(cpu_rdata, e, s);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Fill count and buffer address, status byte last
  task automatic arm(input logic [11:0] bd, input logic [7:0] c, input logic [11:0] b,
                     input logic [7:0] st);
    wr(bd + 12'h001, c);
    wr(bd + 12'h002, b[7:0]);
    wr(bd + 12'h003, {4'h0, b[11:8]});
    wr(bd, st);
  endtask

  // Bounded wait for the completion flag
  task automatic wait_flag;
    int k;
    k = 0;
    while (transfer_complete_flag !== 1'b1 && k < 45)
    begin
      @(negedge ref_clk);
      k++;
    end
    check_bit(transfer_complete_flag, 1'b1, "flag up");
  endtask

  task automatic clear_flag;
    @(posedge ref_clk);
    trn_clr <= 1'b1;
    @(posedge ref_clk);
    trn_clr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic check_hs(input int c, input logic [3:0] p);
    check_byte(8'(ueb_host_inst.hs_cnt), 8'(c), "hs count");
    check_byte({4'h0, ueb_host_inst.hs_last}, {4'h0, p}, "hs pid");
  endtask

  task automatic end_sim;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #200us;
    n_errors++;
    $display("mismatch at %0t: watchdog", $time);
    end_sim();
  end

  // Test sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(DEV_ADDR_ADDR, 8'h00, "addr reset");
    rd_chk(12'hf50, 8'h00, "unmapped");
    for (int n = 0; n < PIPE_COUNT; n++)
    begin
      rd_chk(PIPE_CTRL_BASE + 12'(n), 8'h00, "ctrl reset");
      wr(PIPE_CTRL_BASE + 12'(n), {3'b111, 5'(n) ^ 5'h15});
      rd_chk(PIPE_CTRL_BASE + 12'(n), {3'b000, 5'(n) ^ 5'h15}, "ctrl rw");
      wr(PIPE_CTRL_BASE + 12'(n), 8'h00);
    end
    // Address set, wiped by bus reset, set again
    wr(DEV_ADDR_ADDR, 8'h05);
    rd_chk(DEV_ADDR_ADDR, 8'h05, "addr");
    ueb_host_inst.bus_reset();
    rd_chk(DEV_ADDR_ADDR, 8'h00, "addr bus reset");
    wr(DEV_ADDR_ADDR, 8'h05);
    // Frame number 505h, then writes must not stick
    ueb_host_inst.send_token(PID_SOF, 7'h05, 4'ha);
    idle(4);
    wr(FRAME_LO_ADDR, 8'hff);
    wr(FRAME_HI_ADDR, 8'hff);
    rd_chk(FRAME_LO_ADDR, 8'h05, "frame lo");
    rd_chk(FRAME_HI_ADDR, 8'h05, "frame hi");
    // A frame whose low bits differ from the device address still updates
    ueb_host_inst.send_token(PID_SOF, 7'h43, 4'h5);
    idle(4);
    rd_chk(FRAME_LO_ADDR, 8'hc3, "frame lo 2");
    rd_chk(FRAME_HI_ADDR, 8'h02, "frame hi 2");
    @(posedge ref_clk);
    suspend_flag <= 1'b1;
    idle(3);
    check_bit(frame_valid, 1'b0, "frame suspended");
    @(posedge ref_clk);
    suspend_flag <= 1'b0;
    idle(3);
    check_bit(frame_valid, 1'b1, "frame running");
    // OUT of four bytes on endpoint 1, descriptor 4
    wr(PIPE_CTRL_BASE + 12'h001, 8'h16);
    arm(12'h410, 8'h04, 12'h500, 8'h80);
    rd_chk(12'h410, 8'h80, "owned read");
    ueb_host_inst.send_token(PID_OUT, 7'h05, 4'h1);
    ueb_host_inst.send_data(4, 8'ha0, 1);
    wait_flag();
    idle(2);
    check_hs(1, PID_ACK);
    rd_chk(LAST_STAT_ADDR, 8'h08, "stat out");
    rd_chk(12'h410, 8'h04, "bd stat out");
    rd_chk(12'h411, 8'h04, "bd count");
    for (int i = 0; i < 4; i++)
      rd_chk(12'h500 + 12'(i), 8'ha0 + 8'(i), "out buf");
    clear_flag();
    check_bit(transfer_complete_flag, 1'b0, "flag popped");
    // Disabled endpoint, foreign address, refused SETUP: no answer
    wr(PIPE_CTRL_BASE + 12'h001, 8'h1e);
    ueb_host_inst.send_token(PID_OUT, 7'h05, 4'h3);
    ueb_host_inst.send_token(PID_IN, 7'h06, 4'h1);
    ueb_host_inst.send_token(PID_SETUP, 7'h05, 4'h1);
    idle(20);
    check_hs(1, PID_ACK);
    check_bit(transfer_complete_flag, 1'b0, "no status");
    // SETUP accepted once allowed again
    wr(PIPE_CTRL_BASE + 12'h001, 8'h16);
    arm(12'h410, 8'h08, 12'h520, 8'h80);
    ueb_host_inst.send_token(PID_SETUP, 7'h05, 4'h1);
    ueb_host_inst.send_data(2, 8'h30, 1);
    wait_flag();
    idle(2);
    check_hs(2, PID_ACK);
    rd_chk(LAST_STAT_ADDR, 8'h08, "stat setup");
    rd_chk(12'h410, 8'h34, "bd stat setup");
    rd_chk(12'h411, 8'h02, "bd count setup");
    clear_flag();
    // Receive FIFO filled until it refuses, then drained by an OUT
    arm(12'h410, 8'h28, 12'h700, 8'h80);
    ueb_host_inst.send_data(32, 8'h40, 0);
    idle(1);
    check_bit(rx_ready, 1'b0, "fifo full");
    ueb_host_inst.send_token(PID_OUT, 7'h05, 4'h1);
    ueb_host_inst.send_data(0, 8'h00, 1);
    wait_flag();
    idle(2);
    check_bit(rx_ready, 1'b1, "fifo drained");
    rd_chk(12'h411, 8'h20, "bd count fifo");
    rd_chk(12'h71f, 8'h5f, "fifo last byte");
    clear_flag();
    // Buffer stall, sticky flag, firmware clear, handshake off
    arm(12'h410, 8'h04, 12'h500, 8'h84);
    ueb_host_inst.send_token(PID_OUT, 7'h05, 4'h1);
    idle(6);
    check_hs(4, PID_STALL);
    idle(10);
    rd_chk(PIPE_CTRL_BASE + 12'h001, 8'h17, "stall flag");
    wr(PIPE_CTRL_BASE + 12'h001, 8'h06);
    rd_chk(PIPE_CTRL_BASE + 12'h001, 8'h06, "stall cleared");
    ueb_host_inst.send_token(PID_OUT, 7'h05, 4'h1);
    idle(6);
    check_hs(4, PID_STALL);
    // IN of three bytes on endpoint 2 to a slow host, descriptor 10
    wr(PIPE_CTRL_BASE + 12'h002, 8'h16);
    for (int i = 0; i < 3; i++)
      wr(12'h600 + 12'(i), 8'hc0 + 8'(i));
    arm(12'h428, 8'h03, 12'h600, 8'h80);
    ueb_host_inst.slow = 1'b1;
    ueb_host_inst.send_token(PID_IN, 7'h05, 4'h2);
    wait_flag();
    idle(2);
    check_byte(8'(ueb_host_inst.got.size()), 8'h03, "in bytes");
    for (int i = 0; i < ueb_host_inst.got.size(); i++)
      check_byte(ueb_host_inst.got[i], 8'hc0 + 8'(i), "in data");
    check_hs(4, PID_STALL);
    rd_chk(LAST_STAT_ADDR, 8'h14, "stat in");
    rd_chk(12'h428, 8'h24, "bd stat in");
    rd_chk(12'h429, 8'h03, "bd count in");
    // Three more, queue holds four, the fifth is refused
    for (int k = 0; k < 4; k++)
    begin
      arm(12'h428, 8'h00, 12'h600, 8'h80);
      ueb_host_inst.send_token(PID_IN, 7'h05, 4'h2);
      idle(10);
    end
    check_hs(5, PID_NAK);
    clear_flag();
    check_bit(transfer_complete_flag, 1'b0, "flag dips");
    wait_flag();
    rd_chk(LAST_STAT_ADDR, 8'h14, "stat next");
    for (int k = 0; k < 3; k++)
    begin
      clear_flag();
      idle(10);
    end
    check_bit(transfer_complete_flag, 1'b0, "queue empty");
    end_sim();
  end
endmodule
